// ---- common/iflg_if.sv ----
// Link between the interrupt flag logic and the processor core side.
// Both ends run on the same core clock; all signals are registered at their source.
`timescale 1ns/1ns
interface iflg_if;
   import iflg_pkg::*;
   logic            wr;
   logic            rd;
   logic            clr;
   iflg_reg_t       addr;
   logic [7:0]      wdata;
   logic            sleep;
   logic [7:0]      rdata;
   logic            rvalid;
   logic            irq_high;
   logic            irq_low;
   logic            wake;
   logic            wake_vector;

   modport dev  (input  wr, rd, clr, addr, wdata, sleep,
                 output rdata, rvalid, irq_high, irq_low, wake, wake_vector);
   modport core (output wr, rd, clr, addr, wdata, sleep,
                 input  rdata, rvalid, irq_high, irq_low, wake, wake_vector);
endinterface

// ---- common/iflg_pkg.sv ----
// Constants and types shared by the interrupt flag logic and its core-side end.
// Assumes a single core clock and register indices carried on the link.
package iflg_pkg;

   typedef enum logic [3:0] {
      IFLG_R_MAIN   = 4'h0,
      IFLG_R_CTRL2  = 4'h1,
      IFLG_R_CTRL3  = 4'h2,
      IFLG_R_FLAGS1 = 4'h3,
      IFLG_R_FLAGS2 = 4'h4,
      IFLG_R_PIE1   = 4'h5,
      IFLG_R_PIE2   = 4'h6,
      IFLG_R_IPR1   = 4'h7,
      IFLG_R_IPR2   = 4'h8
   } iflg_reg_t;

   // main_irq_control
   localparam int IFLG_M_GLBL    = 7;
   localparam int IFLG_M_PEIE    = 6;
   localparam int IFLG_M_T0IE    = 5;
   localparam int IFLG_M_P0IE    = 4;
   localparam int IFLG_M_PCIE    = 3;
   localparam int IFLG_M_T0IF    = 2;
   localparam int IFLG_M_P0IF    = 1;
   localparam int IFLG_M_PCIF    = 0;
   // second_irq_control
   localparam int IFLG_C2_EDGE0  = 6;
   localparam int IFLG_C2_EDGE1  = 5;
   localparam int IFLG_C2_EDGE2  = 4;
   localparam int IFLG_C2_T0IP   = 2;
   localparam int IFLG_C2_PCIP   = 0;
   // third_irq_control
   localparam int IFLG_C3_P2IP   = 7;
   localparam int IFLG_C3_P1IP   = 6;
   localparam int IFLG_C3_P2IE   = 4;
   localparam int IFLG_C3_P1IE   = 3;
   localparam int IFLG_C3_P2IF   = 1;
   localparam int IFLG_C3_P1IF   = 0;
   // peripheral_flags_one named bits; receive-full and transmit-empty are read-only, parallel-port is writable
   localparam int IFLG_F1_PARPORT = 7;
   localparam int IFLG_F1_RXFULL  = 5;
   localparam int IFLG_F1_TXEMPTY = 4;

   // Software-writable bit masks; other bits read as zero or come from peripherals
   localparam logic [7:0] IFLG_MASK_MAIN   = 8'hFF;
   localparam logic [7:0] IFLG_MASK_CTRL2  = 8'h75;
   localparam logic [7:0] IFLG_MASK_CTRL3  = 8'hDB;
   localparam logic [7:0] IFLG_MASK_FLAGS1 = 8'hCB;
   localparam logic [7:0] IFLG_MASK_FLAGS2 = 8'h1E;
   localparam logic [7:0] IFLG_MASK_PIE1   = 8'hFB;

   localparam logic [7:0]  IFLG_RST_REG    = 8'h00;
   localparam logic [7:0]  IFLG_CNT8_MAX   = 8'hFF;
   localparam logic [7:0]  IFLG_CNT8_ZERO  = 8'h00;
   localparam logic [15:0] IFLG_CNT16_MAX  = 16'hFFFF;
   localparam logic [15:0] IFLG_CNT16_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      IFLG_H_IDLE  = 2'b00,
      IFLG_H_WRITE = 2'b01,
      IFLG_H_READ  = 2'b10
   } iflg_hstate_t;

endpackage

// ---- sim/iflg_link_props.sv ----
// Concurrent checks on the link between the flag logic and its core end.
// Assumes one core clock; instantiated by the bench beside the link interface.
`timescale 1ns/1ns
module iflg_link_props
   import iflg_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic       clr,
   input  wire iflg_reg_t  addr,
   input  wire logic [7:0] wdata,
   input  wire logic       sleep,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   input  wire logic       irq_high,
   input  wire logic       irq_low,
   input  wire logic       wake,
   input  wire logic       wake_vector
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   logic sleep_seen_reg;
   logic dozing_reg;

   // Mirrors the device's sleep span; the sleep level alone stays high past the wake pulse
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sleep_seen_reg <= 1'b0;
         dozing_reg     <= 1'b0;
      end else begin
         sleep_seen_reg <= sleep;
         dozing_reg     <= sleep && !wake && (dozing_reg || !sleep_seen_reg);
      end
   end

   chk_read_answer: assert property (rd |=> rvalid ##1 !rvalid)
      else $error("read got no single answer");
   chk_flags1_hole: assert property (rd && addr == IFLG_R_FLAGS1 |=> rdata[2] == 1'b0)
      else $error("flag register one bit 2 not zero");
   chk_flags2_zero: assert property (rd && addr == IFLG_R_FLAGS2 |=> rdata[7:5] == 3'h0 && !rdata[0])
      else $error("flag register two unused bits not zero");
   chk_one_vector: assert property (!(irq_high && irq_low))
      else $error("both vectors requested");
   chk_clr_target: assert property (clr |-> addr == IFLG_R_FLAGS1 || addr == IFLG_R_FLAGS2)
      else $error("clear aimed at a non-flag register");
   chk_clr_then_wr: assert property (clr |=> wr && (addr == IFLG_R_PIE1 || addr == IFLG_R_PIE2) && $stable(wdata))
      else $error("enable write did not follow its clear");
   chk_wake_asleep: assert property (wake |-> $past(sleep) && !$past(wake))
      else $error("wake outside sleep or not a pulse");
   chk_quiet_asleep: assert property (sleep [*3] ##0 dozing_reg |-> !irq_high && !irq_low)
      else $error("request while asleep");
   chk_wake_vec_hold: assert property (!wake |-> $stable(wake_vector))
      else $error("wake vector changed without wake");
endmodule

// ---- sim/tb.sv ----
// Self-checking bench: core end and flag logic joined by the link interface.
// Drives the core command port and all event inputs 1 ns after each rising edge.
`timescale 1ns/1ns
module tb;
   import iflg_pkg::*;
   logic        i_clk, i_reset_n, i_cmd_valid, i_cmd_write, i_sleep_req, i_motor_fw, i_small_pkg;
   iflg_reg_t   i_cmd_addr;
   logic [7:0]  i_cmd_data, i_periph1_evt, i_periph2_evt;
   logic [2:0]  i_ext_pins;
   logic [3:0]  i_port_b_pins;
   logic [15:0] i_tmr0_count;
   logic        i_tmr0_16bit, i_rx_full, i_tx_empty;
   logic        o_cmd_ready, o_rd_valid, o_irq_high, o_irq_low, o_wake, o_wake_vector;
   logic [7:0]  o_rd_data;
   int          err_count, samples_checked, n;
   logic [7:0]  c3_cfg [5] = '{8'h08, 8'h48, 8'h10, 8'h90, 8'h00};
   int          pin_of [5] = '{1, 1, 2, 2, 1};
   logic [1:0]  vec_exp [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0};

   iflg_if u_link ();
   iflg_device u_iflg_device (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(u_link), .i_ext_pins(i_ext_pins),
      .i_port_b_pins(i_port_b_pins), .i_tmr0_count(i_tmr0_count), .i_tmr0_16bit(i_tmr0_16bit),
      .i_periph1_evt(i_periph1_evt), .i_periph2_evt(i_periph2_evt), .i_rx_full(i_rx_full), .i_tx_empty(i_tx_empty));
   iflg_core u_iflg_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(u_link), .i_cmd_valid(i_cmd_valid),
      .i_cmd_write(i_cmd_write), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data), .i_sleep_req(i_sleep_req),
      .i_motor_fw(i_motor_fw), .i_small_pkg(i_small_pkg), .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid),
      .o_rd_data(o_rd_data), .o_irq_high(o_irq_high), .o_irq_low(o_irq_low), .o_wake(o_wake),
      .o_wake_vector(o_wake_vector));
   iflg_link_props u_iflg_link_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .wr(u_link.wr), .rd(u_link.rd),
      .clr(u_link.clr), .addr(u_link.addr), .wdata(u_link.wdata), .sleep(u_link.sleep), .rdata(u_link.rdata),
      .rvalid(u_link.rvalid), .irq_high(u_link.irq_high), .irq_low(u_link.irq_low), .wake(u_link.wake),
      .wake_vector(u_link.wake_vector));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic cyc(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_irq(input logic h, input logic l);
      chk_bit(o_irq_high, h);
      chk_bit(o_irq_low, l);
   endtask

   // Command is held until an edge samples ready high, then released for one edge so a write other than a PIE1/PIE2 write has landed
   task automatic cmd(input logic w, input iflg_reg_t a, input logic [7:0] d);
      int k;
      k = 0;
      i_cmd_valid = 1'b1;
      i_cmd_write = w;
      i_cmd_addr  = a;
      i_cmd_data  = d;
      while (o_cmd_ready !== 1'b1 && k < 50) begin
         cyc(1);
         k++;
      end
      cyc(1);
      i_cmd_valid = 1'b0;
      cyc(1);
   endtask

   task automatic rd_reg(input iflg_reg_t a, input logic [7:0] exp);
      int k;
      k = 0;
      cmd(1'b0, a, 8'h00);
      while (o_rd_valid !== 1'b1 && k < 10) begin
         cyc(1);
         k++;
      end
      chk_bit(o_rd_valid, 1'b1);
      chk_byte(o_rd_data, exp);
   endtask

   task automatic pin_pulse(input int p);
      i_ext_pins[p] = 1'b1;
      cyc(3);
      i_ext_pins[p] = 1'b0;
      cyc(4);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      {i_reset_n, i_cmd_valid, i_cmd_write, i_sleep_req, i_motor_fw, i_small_pkg, i_tmr0_16bit} = '0;
      {i_rx_full, i_tx_empty, i_ext_pins, i_port_b_pins, i_tmr0_count, i_cmd_data} = '0;
      {i_periph1_evt, i_periph2_evt} = '0;
      i_cmd_addr = IFLG_R_MAIN;
      repeat (8) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      cyc(2);
      for (int r = 0; r < 9; r++) rd_reg(iflg_reg_t'(r[3:0]), 8'h00);
      i_rx_full = 1'b1;
      {i_periph1_evt, i_periph2_evt} = 16'hFFFF;
      cyc(1);
      {i_periph1_evt, i_periph2_evt} = 16'h0000;
      cyc(3);
      chk_irq(1'b0, 1'b0);
      rd_reg(IFLG_R_FLAGS1, 8'hEB);
      rd_reg(IFLG_R_FLAGS2, 8'h1E);
      cmd(1'b1, IFLG_R_FLAGS2, 8'h00);
      rd_reg(IFLG_R_FLAGS2, 8'h00);
      i_small_pkg = 1'b1;
      cmd(1'b1, IFLG_R_FLAGS1, 8'hFF);
      rd_reg(IFLG_R_FLAGS1, 8'h6B);
      {i_small_pkg, i_rx_full, i_tx_empty} = 3'h1;
      cmd(1'b1, IFLG_R_FLAGS1, 8'h00);
      rd_reg(IFLG_R_FLAGS1, 8'h10);
      // Peripheral path needs global and peripheral enables
      cmd(1'b1, IFLG_R_MAIN, 8'hC0);
      cmd(1'b1, IFLG_R_PIE2, 8'h02);
      i_periph2_evt = 8'h02;
      cyc(1);
      i_periph2_evt = 8'h00;
      cyc(3);
      chk_irq(1'b0, 1'b1);
      cmd(1'b1, IFLG_R_IPR2, 8'h02);
      cyc(3);
      chk_irq(1'b1, 1'b0);
      cmd(1'b1, IFLG_R_PIE2, 8'h00);
      cmd(1'b1, IFLG_R_FLAGS2, 8'h00);
      for (int k = 0; k < 2; k++) begin
         cmd(1'b1, IFLG_R_CTRL2, k ? 8'h30 : 8'h40);
         i_ext_pins = 3'h7;
         cyc(3);
         rd_reg(IFLG_R_MAIN, k ? 8'hC0 : 8'hC2);
         rd_reg(IFLG_R_CTRL3, k ? 8'h03 : 8'h00);
         cmd(1'b1, IFLG_R_MAIN, 8'hC0);
         cmd(1'b1, IFLG_R_CTRL3, 8'h00);
         i_ext_pins = 3'h0;
         cyc(3);
         rd_reg(IFLG_R_MAIN, k ? 8'hC2 : 8'hC0);
         rd_reg(IFLG_R_CTRL3, k ? 8'h00 : 8'h03);
         cmd(1'b1, IFLG_R_MAIN, 8'hC0);
         cmd(1'b1, IFLG_R_CTRL3, 8'h00);
      end
      cmd(1'b1, IFLG_R_CTRL2, 8'h40);
      for (int k = 0; k < 5; k++) begin
         cmd(1'b1, IFLG_R_CTRL3, c3_cfg[k]);
         pin_pulse(pin_of[k]);
         chk_irq(vec_exp[k][1], vec_exp[k][0]);
         cmd(1'b1, IFLG_R_CTRL3, 8'h00);
      end
      cmd(1'b1, IFLG_R_MAIN, 8'h90);
      pin_pulse(0);
      chk_irq(1'b1, 1'b0);
      for (int k = 0; k < 2; k++) begin
         cmd(1'b1, IFLG_R_MAIN, k ? 8'h90 : 8'h10);
         i_sleep_req = 1'b1;
         cyc(3);
         i_ext_pins[0] = 1'b1;
         n = 0;
         while (o_wake !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
         end
         chk_bit(o_wake, 1'b1);
         chk_bit(o_wake_vector, k[0]);
         {i_ext_pins[0], i_sleep_req} = 2'h0;
         cyc(2);
      end
      i_motor_fw = 1'b1;
      cmd(1'b1, IFLG_R_MAIN, 8'h90);
      rd_reg(IFLG_R_MAIN, 8'h80);
      i_motor_fw = 1'b0;
      cmd(1'b1, IFLG_R_CTRL2, 8'h44);
      cmd(1'b1, IFLG_R_MAIN, 8'hA0);
      for (int k = 0; k < 3; k++) begin
         i_tmr0_count = 16'h00FE + k[15:0];
         cyc(1);
      end
      i_tmr0_count = 16'h0000;
      cyc(3);
      chk_irq(1'b1, 1'b0);
      rd_reg(IFLG_R_MAIN, 8'hA4);
      cmd(1'b1, IFLG_R_MAIN, 8'hA0);
      i_tmr0_16bit = 1'b1;
      i_tmr0_count = 16'h00FF;
      cyc(1);
      i_tmr0_count = 16'h0100;
      cyc(3);
      rd_reg(IFLG_R_MAIN, 8'hA0);
      cmd(1'b1, IFLG_R_CTRL2, 8'h40);
      i_tmr0_count = 16'hFFFF;
      cyc(1);
      i_tmr0_count = 16'h0000;
      cyc(3);
      chk_irq(1'b0, 1'b1);
      cmd(1'b1, IFLG_R_CTRL2, 8'h41);
      cmd(1'b1, IFLG_R_MAIN, 8'h88);
      i_port_b_pins = 4'h8;
      cyc(4);
      chk_irq(1'b1, 1'b0);
      rd_reg(IFLG_R_MAIN, 8'h89);
      cmd(1'b1, IFLG_R_CTRL2, 8'h40);
      cyc(3);
      chk_irq(1'b0, 1'b1);
      conclude();
   end

   // Whole sequence takes well under two thousand cycles
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      conclude();
   end
endmodule

// ---- src/iflg_core.sv ----
// Core-side end: turns software register commands into link cycles.
// Assumes the user side holds a command until o_cmd_ready accepts it.
`timescale 1ns/1ns
module iflg_core
   import iflg_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   iflg_if.core            link,
   input  wire logic       i_cmd_valid,
   input  wire logic       i_cmd_write,
   input  wire iflg_reg_t  i_cmd_addr,
   input  wire logic [7:0] i_cmd_data,
   input  wire logic       i_sleep_req,
   input  wire logic       i_motor_fw,
   input  wire logic       i_small_pkg,
   output logic            o_cmd_ready,
   output logic            o_rd_valid,
   output logic [7:0]      o_rd_data,
   output logic            o_irq_high,
   output logic            o_irq_low,
   output logic            o_wake,
   output logic            o_wake_vector
);

   typedef struct packed {
      iflg_hstate_t state;
      logic         wr;
      logic         rd;
      logic         clr;
      iflg_reg_t    addr;
      logic [7:0]   wdata;
      iflg_reg_t    pend_addr;
      logic [7:0]   pend_data;
      logic         sleep;
      logic         ready;
      logic         rd_valid;
      logic [7:0]   rd_data;
      logic         irq_high;
      logic         irq_low;
      logic         wake;
      logic         wake_vector;
   } iflg_core_state_t;

   iflg_core_state_t st_reg;
   iflg_core_state_t st_next;

   always_comb begin
      logic [7:0] d;
      d = i_cmd_data;
      st_next = st_reg;
      st_next.wr       = 1'b0;
      st_next.rd       = 1'b0;
      st_next.clr      = 1'b0;
      st_next.rd_valid = 1'b0;
      st_next.sleep    = i_sleep_req;
      st_next.irq_high    = link.irq_high;
      st_next.irq_low     = link.irq_low;
      st_next.wake        = link.wake;
      st_next.wake_vector = link.wake_vector;

      // Enabling a source in main or control three clears its flag in the same write so stale events never fire
      unique case (i_cmd_addr)
         IFLG_R_MAIN: begin
            d[IFLG_M_P0IE] = d[IFLG_M_P0IE] & ~i_motor_fw;
            d[2:0] = d[2:0] & ~d[5:3];
         end
         IFLG_R_CTRL3:  d[1:0] = d[1:0] & ~d[4:3];
         IFLG_R_FLAGS1: d[IFLG_F1_PARPORT] = d[IFLG_F1_PARPORT] & ~i_small_pkg;
         default: ;
      endcase

      unique case (st_reg.state)
         IFLG_H_IDLE: begin
            st_next.ready = 1'b1;
            if (i_cmd_valid && st_reg.ready) begin
               st_next.ready = 1'b0;
               st_next.addr  = i_cmd_addr;
               st_next.wdata = d;
               if (!i_cmd_write) begin
                  st_next.rd    = 1'b1;
                  st_next.state = IFLG_H_READ;
               end else if (i_cmd_addr == IFLG_R_PIE1 || i_cmd_addr == IFLG_R_PIE2) begin
                  // Clear the matching peripheral flags one cycle before the enable lands
                  st_next.clr       = 1'b1;
                  st_next.addr      = (i_cmd_addr == IFLG_R_PIE1) ? IFLG_R_FLAGS1 : IFLG_R_FLAGS2;
                  st_next.pend_addr = i_cmd_addr;
                  st_next.pend_data = d;
                  st_next.state     = IFLG_H_WRITE;
               end else begin
                  st_next.wr = 1'b1;
               end
            end
         end
         IFLG_H_WRITE: begin
            st_next.wr    = 1'b1;
            st_next.addr  = st_reg.pend_addr;
            st_next.wdata = st_reg.pend_data;
            st_next.state = IFLG_H_IDLE;
         end
         IFLG_H_READ: begin
            if (link.rvalid) begin
               st_next.rd_valid = 1'b1;
               st_next.rd_data  = link.rdata;
               st_next.state    = IFLG_H_IDLE;
            end
         end
         default: st_next.state = IFLG_H_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.wr    = st_reg.wr;
   assign link.rd    = st_reg.rd;
   assign link.clr   = st_reg.clr;
   assign link.addr  = st_reg.addr;
   assign link.wdata = st_reg.wdata;
   assign link.sleep = st_reg.sleep;
   assign o_cmd_ready   = st_reg.ready;
   assign o_rd_valid    = st_reg.rd_valid;
   assign o_rd_data     = st_reg.rd_data;
   assign o_irq_high    = st_reg.irq_high;
   assign o_irq_low     = st_reg.irq_low;
   assign o_wake        = st_reg.wake;
   assign o_wake_vector = st_reg.wake_vector;

endmodule

// ---- src/iflg_device.sv ----
// Interrupt flag, enable and priority logic with sleep wake-up.
// Assumes pins, event pulses and the timer count are synchronous to i_clk.
// Operation
// - Flags set on event regardless of enables
// - Software clears flag before enable, after service
// - Flag register one layout, bit 2 zero
// - Flag register two: bits 4..1, rest zero
// - External pins edge triggered by edge select
// - Valid pin edge sets its flag
// - Cleared pin enable blocks request, not flag
// - Service routine clears pin flag before re-enable
// - Enabled pin wakes from sleep if enabled before
// - Vector after wake only when global enable set
// - Pin zero always high priority
// - Pin one/two priority at control-three bits 6,7
// - Motor firmware: keep pin zero enable zero
// - Timer zero 8-bit rollover sets flag
// - Timer zero 16-bit rollover of pair sets flag
// - Timer zero enable main bit5, priority bit2
// - Port B 7..4 change sets main bit0
// - Port change enable bit3, priority bit0
// - Small package: keep parallel-port flag clear
`timescale 1ns/1ns
module iflg_device
   import iflg_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   iflg_if.dev              link,
   input  wire logic [2:0]  i_ext_pins,
   input  wire logic [3:0]  i_port_b_pins,
   input  wire logic [15:0] i_tmr0_count,
   input  wire logic        i_tmr0_16bit,
   input  wire logic [7:0]  i_periph1_evt,
   input  wire logic [7:0]  i_periph2_evt,
   input  wire logic        i_rx_full,
   input  wire logic        i_tx_empty
);

   typedef struct packed {
      logic [7:0]  main;
      logic [7:0]  ctrl2;
      logic [7:0]  ctrl3;
      logic [7:0]  flags1;
      logic [7:0]  flags2;
      logic [7:0]  pie1;
      logic [7:0]  pie2;
      logic [7:0]  ipr1;
      logic [7:0]  ipr2;
      logic        primed;
      logic [2:0]  pin_prev;
      logic [3:0]  port_b_pins_prev;
      logic [15:0] tmr_prev;
      logic        sleep_prev;
      logic        asleep;
      logic [2:0]  wake_en;
      logic        irq_high;
      logic        irq_low;
      logic        wake;
      logic        wake_vector;
      logic [7:0]  rdata;
      logic        rvalid;
   } iflg_dev_state_t;

   iflg_dev_state_t st_reg;
   iflg_dev_state_t st_next;

   logic [2:0] edge_sel;
   logic [2:0] pin_edge;
   logic [7:0] flags1_view;

   assign edge_sel = {st_reg.ctrl2[IFLG_C2_EDGE2], st_reg.ctrl2[IFLG_C2_EDGE1], st_reg.ctrl2[IFLG_C2_EDGE0]};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         // Selected edge per pin; suppressed until the previous level is known
         assign pin_edge[gi] = st_reg.primed & (edge_sel[gi] ? (i_ext_pins[gi] & ~st_reg.pin_prev[gi])
                                                             : (~i_ext_pins[gi] & st_reg.pin_prev[gi]));
      end
   endgenerate

   // Receive-full and transmit-empty follow the serial port live
   always_comb begin
      flags1_view = st_reg.flags1 & IFLG_MASK_FLAGS1;
      flags1_view[IFLG_F1_RXFULL]  = i_rx_full;
      flags1_view[IFLG_F1_TXEMPTY] = i_tx_empty;
   end

   always_comb begin
      logic       t0_roll;
      logic       pc_chg;
      logic [7:0] wd;
      logic       src_hi;
      logic       src_lo;
      logic       pend_p1;
      logic       pend_p2;
      logic [7:0] per1;
      logic [7:0] per2;
      logic [2:0] pin_flags;
      t0_roll = 1'b0;
      pc_chg  = 1'b0;
      wd      = link.wdata;
      src_hi  = 1'b0;
      src_lo  = 1'b0;
      pend_p1 = 1'b0;
      pend_p2 = 1'b0;
      per1    = 8'h00;
      per2    = 8'h00;
      pin_flags = 3'b000;
      st_next = st_reg;

      st_next.primed     = 1'b1;
      st_next.pin_prev   = i_ext_pins;
      st_next.port_b_pins_prev = i_port_b_pins;
      st_next.tmr_prev   = i_tmr0_count;
      st_next.sleep_prev = link.sleep;

      if (st_reg.primed) begin
         if (i_tmr0_16bit) begin
            t0_roll = (st_reg.tmr_prev == IFLG_CNT16_MAX) && (i_tmr0_count == IFLG_CNT16_ZERO);
         end else begin
            t0_roll = (st_reg.tmr_prev[7:0] == IFLG_CNT8_MAX) && (i_tmr0_count[7:0] == IFLG_CNT8_ZERO);
         end
         pc_chg = |(i_port_b_pins ^ st_reg.port_b_pins_prev);
      end

      // Software writes and clears first; hardware events are OR-ed last so a set wins
      if (link.wr) begin
         unique case (link.addr)
            IFLG_R_MAIN:   st_next.main   = wd & IFLG_MASK_MAIN;
            IFLG_R_CTRL2:  st_next.ctrl2  = wd & IFLG_MASK_CTRL2;
            IFLG_R_CTRL3:  st_next.ctrl3  = wd & IFLG_MASK_CTRL3;
            IFLG_R_FLAGS1: st_next.flags1 = wd & IFLG_MASK_FLAGS1;
            IFLG_R_FLAGS2: st_next.flags2 = wd & IFLG_MASK_FLAGS2;
            IFLG_R_PIE1:   st_next.pie1   = wd & IFLG_MASK_PIE1;
            IFLG_R_PIE2:   st_next.pie2   = wd & IFLG_MASK_FLAGS2;
            IFLG_R_IPR1:   st_next.ipr1   = wd & IFLG_MASK_PIE1;
            IFLG_R_IPR2:   st_next.ipr2   = wd & IFLG_MASK_FLAGS2;
            default: ;
         endcase
      end
      if (link.clr) begin
         unique case (link.addr)
            IFLG_R_FLAGS1: st_next.flags1 = st_next.flags1 & ~wd;
            IFLG_R_FLAGS2: st_next.flags2 = st_next.flags2 & ~wd;
            default: ;
         endcase
      end

      st_next.flags1 = st_next.flags1 | (i_periph1_evt & IFLG_MASK_FLAGS1);
      st_next.flags2 = st_next.flags2 | (i_periph2_evt & IFLG_MASK_FLAGS2);
      st_next.main[IFLG_M_T0IF]  = st_next.main[IFLG_M_T0IF] | t0_roll;
      st_next.main[IFLG_M_P0IF]  = st_next.main[IFLG_M_P0IF] | pin_edge[0];
      st_next.main[IFLG_M_PCIF]  = st_next.main[IFLG_M_PCIF] | pc_chg;
      st_next.ctrl3[IFLG_C3_P1IF] = st_next.ctrl3[IFLG_C3_P1IF] | pin_edge[1];
      st_next.ctrl3[IFLG_C3_P2IF] = st_next.ctrl3[IFLG_C3_P2IF] | pin_edge[2];

      // Request routing from the registered flags and enables, with receive-full and transmit-empty taken live
      pend_p1 = st_reg.ctrl3[IFLG_C3_P1IE] & st_reg.ctrl3[IFLG_C3_P1IF];
      pend_p2 = st_reg.ctrl3[IFLG_C3_P2IE] & st_reg.ctrl3[IFLG_C3_P2IF];
      per1 = flags1_view & st_reg.pie1;
      per2 = st_reg.flags2 & st_reg.pie2;
      src_hi = (st_reg.main[IFLG_M_P0IE] & st_reg.main[IFLG_M_P0IF])
             | (pend_p1 & st_reg.ctrl3[IFLG_C3_P1IP])
             | (pend_p2 & st_reg.ctrl3[IFLG_C3_P2IP])
             | (st_reg.main[IFLG_M_T0IE] & st_reg.main[IFLG_M_T0IF] & st_reg.ctrl2[IFLG_C2_T0IP])
             | (st_reg.main[IFLG_M_PCIE] & st_reg.main[IFLG_M_PCIF] & st_reg.ctrl2[IFLG_C2_PCIP])
             | (st_reg.main[IFLG_M_PEIE] & (|(per1 & st_reg.ipr1) | |(per2 & st_reg.ipr2)));
      src_lo = (pend_p1 & ~st_reg.ctrl3[IFLG_C3_P1IP])
             | (pend_p2 & ~st_reg.ctrl3[IFLG_C3_P2IP])
             | (st_reg.main[IFLG_M_T0IE] & st_reg.main[IFLG_M_T0IF] & ~st_reg.ctrl2[IFLG_C2_T0IP])
             | (st_reg.main[IFLG_M_PCIE] & st_reg.main[IFLG_M_PCIF] & ~st_reg.ctrl2[IFLG_C2_PCIP])
             | (st_reg.main[IFLG_M_PEIE] & (|(per1 & ~st_reg.ipr1) | |(per2 & ~st_reg.ipr2)));
      st_next.irq_high = st_reg.main[IFLG_M_GLBL] & ~st_reg.asleep & src_hi;
      st_next.irq_low  = st_reg.main[IFLG_M_GLBL] & ~st_reg.asleep & src_lo & ~src_hi;

      // Sleep: pin enables are frozen at entry; later enable changes do not arm wake-up
      st_next.wake = 1'b0;
      pin_flags = {st_reg.ctrl3[IFLG_C3_P2IF], st_reg.ctrl3[IFLG_C3_P1IF], st_reg.main[IFLG_M_P0IF]};
      if (link.sleep & ~st_reg.sleep_prev) begin
         st_next.asleep  = 1'b1;
         st_next.wake_en = {st_reg.ctrl3[IFLG_C3_P2IE], st_reg.ctrl3[IFLG_C3_P1IE], st_reg.main[IFLG_M_P0IE]};
      end else if (st_reg.asleep & |(pin_flags & st_reg.wake_en)) begin
         st_next.asleep      = 1'b0;
         st_next.wake        = 1'b1;
         st_next.wake_vector = st_reg.main[IFLG_M_GLBL];
      end

      st_next.rvalid = link.rd;
      if (link.rd) begin
         unique case (link.addr)
            IFLG_R_MAIN:   st_next.rdata = st_reg.main;
            IFLG_R_CTRL2:  st_next.rdata = st_reg.ctrl2;
            IFLG_R_CTRL3:  st_next.rdata = st_reg.ctrl3;
            IFLG_R_FLAGS1: st_next.rdata = flags1_view;
            IFLG_R_FLAGS2: st_next.rdata = st_reg.flags2;
            IFLG_R_PIE1:   st_next.rdata = st_reg.pie1;
            IFLG_R_PIE2:   st_next.rdata = st_reg.pie2;
            IFLG_R_IPR1:   st_next.rdata = st_reg.ipr1;
            IFLG_R_IPR2:   st_next.rdata = st_reg.ipr2;
            default:       st_next.rdata = IFLG_RST_REG;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.rdata       = st_reg.rdata;
   assign link.rvalid      = st_reg.rvalid;
   assign link.irq_high    = st_reg.irq_high;
   assign link.irq_low     = st_reg.irq_low;
   assign link.wake        = st_reg.wake;
   assign link.wake_vector = st_reg.wake_vector;

endmodule
